// ===== hdl/hpsc_pkg.sv
// Types shared by the system control block
package hpsc_pkg;
   typedef enum logic [1:0] {
      HPSC_LEVEL_STANDARD,
      HPSC_LEVEL_ONE,
      HPSC_LEVEL_TWO,
      HPSC_LEVEL_THREE
   } hpsc_level_t;
endpackage

// ===== hdl/hpsc_regs.svh
// Offsets, field positions, masks and reset values of the system control block
`ifndef HPSC_REGS_SVH
`define HPSC_REGS_SVH
`define HPSC_ADDR_W            4
`define HPSC_SYSCTL2_OFFSET    4'h0
`define HPSC_EXTCTL_OFFSET     4'h1
`define HPSC_STATUS_OFFSET     4'h2
`define HPSC_SYSCTL2_RESET     8'h00
`define HPSC_EXTCTL_RESET      8'h00
`define HPSC_RSVD_MASK         8'hEF
`define HPSC_EXTCTL_MASK       8'h03
`define HPSC_LVL_HI_BIT        7
`define HPSC_LVL_LO_BIT        6
`define HPSC_PULLUP_BIT        5
`define HPSC_RSVD_BIT          4
`define HPSC_SHUTDOWN_EN_BIT   3
`define HPSC_CH4_EN_BIT        2
`define HPSC_CH3_EN_BIT        1
`define HPSC_MASTER_EN_BIT     0
`define HPSC_CH2_EN_BIT        0
`define HPSC_FGA20_EN_BIT      1
`endif

// ===== hdl/hpsc_sync.sv
// Two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
module hpsc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_one;

   // First stage feeds only the second
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end
endmodule

// ===== hdl/hpsc_top.sv
// System control register two with host port enables and pin shutdown
// What this block does
// - Bits 7:6 select port input level: standard, level 1, 2 or 3.
// - Bit 5 selects pull-up current: 0 standard, 1 current limited.
// - Bit 2 enables channel 4 and its select pin.
// - Bit 1 enables channel 3 and its select pin.
// - Channel 3 and 4 enables act only while master enable is 1.
// - Bit 0 gates all host functions, channel, gate A20 and shutdown enables.
// - Master enable acts only in single-chip mode.
// - Channel 2 select from primary pin, or alternate pin when gate A20 enabled.
`timescale 1ns/1ps
`include "hpsc_regs.svh"
module hpsc_top (
   input  wire logic                    core_clk,
   input  wire logic                    reset,
   input  wire logic [`HPSC_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_write,
   input  wire logic                    reg_read,
   output logic      [7:0]              reg_rdata,
   input  wire logic                    single_chip_mode,
   input  wire logic                    host_port_shutdown_input,
   input  wire logic                    channel_two_select_n,
   input  wire logic                    alternate_channel_two_select_n,
   output logic      [1:0]              port_level_select,
   output logic                         pullup_current_limit,
   output logic                         host_port_active,
   output logic                         host_pins_float,
   output logic                         channel_two_active,
   output logic                         channel_three_active,
   output logic                         channel_four_active,
   output logic                         fast_gate_a20_active,
   output logic                         channel_two_chip_select
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [7:0] system_control_two;                // Documented control register
   logic [7:0] ext_control;                       // Channel 2 and gate A20 enables
   logic [3:0] pins_active;                       // Pin requests, active high, before sync
   logic [3:0] pins_sync;                         // Pin requests after two flops
   logic       shutdown_sync;                     // Shutdown request seen by the core
   logic       mode_sync;                         // Single-chip mode seen by the core
   logic       cs2_sync;                          // Primary channel 2 select asserted
   logic       alternate_channel_two_select_sync;                         // Alternate channel 2 select asserted

   // ****************************************************************
   // Usage notes
   // ****************************************************************
   // Offset 0 holds the documented control register; bit 4 always stores 0.
   // Offset 1 holds the channel 2 enable in bit 0 and the gate A20 enable in bit 1;
   // its upper six bits read 0.
   // Offset 2 is read only and shows what is in force, from bit 0 up:
   //    channel 2, channel 3, channel 4, gate A20, master, mode, float, zero.
   // Unmapped offsets read 0 and ignore writes.
   // Writes and reads never wait; a write lands at the edge that takes it and
   // reaches the outputs one edge later.
   // Read data stand for one cycle after the read strobe and are 0 otherwise.
   // Pin changes reach the outputs three edges later: two sync flops, one output flop.
   // Every enable except the port fields waits on the synchronised mode pin, so the
   // host port stays off for three edges after reset even in single-chip mode.
   // The shutdown input is active high and counts only while the master enable is in
   // force and the shutdown enable is set.
   // Floating the pins drives every host activity output low; the pad logic that
   // turns host_pins_float into high impedance sits outside this block.
   // The gate A20 bit steers the channel 2 select pin choice even while channel 2 is
   // off; the select output stays low until channel 2 is in force.
   // Software must keep bit 4 at 0; the block stores 0 there whatever is written,
   // so a stray 1 cannot leak into a later read.

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // True when the bus address names the given register
   function automatic logic addr_hit(input logic [`HPSC_ADDR_W-1:0] addr,
                                     input logic [`HPSC_ADDR_W-1:0] offset);
      return addr == offset;
   endfunction

   // A host function runs only while it is enabled and the pins are not floated
   function automatic logic run_unless_float(input logic enabled,
                                             input logic floated);
      return enabled && !floated;
   endfunction

   // Register next value: masked write data on a write, the old value otherwise
   function automatic logic [7:0] write_merge(input logic       write_now,
                                              input logic [7:0] write_val,
                                              input logic [7:0] old_val);
      return write_now ? write_val : old_val;
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Selects turn active high before the flops, so the flops' reset value
   // of 0 means idle and no false select follows reset
   assign pins_active = {host_port_shutdown_input, single_chip_mode,
                         ~channel_two_select_n, ~alternate_channel_two_select_n};

   hpsc_sync #(
      .WIDTH(4)
   ) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in (pins_active),
      .sync_out (pins_sync)
   );

   // Name the synchronised pins
   assign shutdown_sync = pins_sync[3];
   assign mode_sync     = pins_sync[2];
   assign cs2_sync      = pins_sync[1];
   assign alternate_channel_two_select_sync     = pins_sync[0];

   // ****************************************************************
   // Decode
   // ****************************************************************
   // Register select and write strobes
   wire        hit_sysctl2  = addr_hit(reg_addr, `HPSC_SYSCTL2_OFFSET);
   wire        hit_extctl   = addr_hit(reg_addr, `HPSC_EXTCTL_OFFSET);
   wire        hit_status   = addr_hit(reg_addr, `HPSC_STATUS_OFFSET);
   wire        wr_sysctl2   = reg_write && hit_sysctl2;
   wire        wr_extctl    = reg_write && hit_extctl;
   // Reserved bit held at 0 whatever software writes
   wire [7:0]  sysctl2_wval = reg_wdata & `HPSC_RSVD_MASK;
   wire [7:0]  extctl_wval  = reg_wdata & `HPSC_EXTCTL_MASK;

   // Master enable counts only in single-chip mode; every other enable waits on it
   wire master_on = system_control_two[`HPSC_MASTER_EN_BIT] && mode_sync;
   wire ch2_on    = master_on && ext_control[`HPSC_CH2_EN_BIT];
   wire ch3_on    = master_on && system_control_two[`HPSC_CH3_EN_BIT];
   wire ch4_on    = master_on && system_control_two[`HPSC_CH4_EN_BIT];
   wire a20_on    = master_on && ext_control[`HPSC_FGA20_EN_BIT];
   wire sd_on     = master_on && system_control_two[`HPSC_SHUTDOWN_EN_BIT];
   // Shutdown input only looked at while shutdown function is enabled
   wire float_now = sd_on && shutdown_sync;
   // Channel 2 select pin chosen by gate A20 enable
   wire cs2_pick  = ext_control[`HPSC_FGA20_EN_BIT] ? alternate_channel_two_select_sync : cs2_sync;
   wire cs2_now   = run_unless_float(ch2_on, float_now) && cs2_pick;

   // ****************************************************************
   // Next values
   // ****************************************************************
   // Control registers take masked write data when addressed
   wire [7:0] next_system_control_two      = write_merge(wr_sysctl2, sysctl2_wval, system_control_two);
   wire [7:0] next_ext_control             = write_merge(wr_extctl, extctl_wval, ext_control);
   // Port fields follow the register bits directly
   wire [1:0] next_port_level_select       = system_control_two[`HPSC_LVL_HI_BIT:`HPSC_LVL_LO_BIT];
   wire       next_pullup_current_limit    = system_control_two[`HPSC_PULLUP_BIT];
   // Host functions drop while the pins are floated
   wire       next_host_port_active        = run_unless_float(master_on, float_now);
   wire       next_host_pins_float         = float_now;
   wire       next_channel_two_active      = run_unless_float(ch2_on, float_now);
   wire       next_channel_three_active    = run_unless_float(ch3_on, float_now);
   wire       next_channel_four_active     = run_unless_float(ch4_on, float_now);
   wire       next_fast_gate_a20_active    = run_unless_float(a20_on, float_now);
   wire       next_channel_two_chip_select = cs2_now;

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Live status word, layout as in the usage notes
   wire [7:0] status_val     = {1'b0, float_now, mode_sync, master_on,
                                a20_on, ch4_on, ch3_on, ch2_on};
   // Register read back selected by offset, 0 for unmapped offsets
   wire [7:0] rd_mux         = hit_sysctl2 ? system_control_two :
                               hit_extctl  ? ext_control :
                               hit_status  ? status_val : 8'h00;
   // Read data stand only in the cycle after the strobe
   wire [7:0] next_reg_rdata = reg_read ? rd_mux : 8'h00;

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Documented control register; every bit clears on reset so the host
   // port starts off at standard level and current
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         system_control_two <= `HPSC_SYSCTL2_RESET;
      end else begin
         system_control_two <= next_system_control_two;
      end
   end

   // Channel 2 and gate A20 enables
   // Cleared on reset like the main register
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ext_control <= `HPSC_EXTCTL_RESET;
      end else begin
         ext_control <= next_ext_control;
      end
   end

   // Read data register
   // Holds 0 outside the slot after a read strobe
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // Port level output, registered so the input buffers
   // never see a decode glitch on their level select
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         port_level_select <= hpsc_pkg::HPSC_LEVEL_STANDARD;
      end else begin
         port_level_select <= next_port_level_select;
      end
   end

   // Pull-up current select output
   // Reset picks the standard current
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pullup_current_limit <= 1'b0;
      end else begin
         pullup_current_limit <= next_pullup_current_limit;
      end
   end

   // Master activity output
   // Low during reset and while the pins float
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         host_port_active <= 1'b0;
      end else begin
         host_port_active <= next_host_port_active;
      end
   end

   // Float request to the pad logic
   // Pads go high impedance while this is high
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         host_pins_float <= 1'b0;
      end else begin
         host_pins_float <= next_host_pins_float;
      end
   end

   // Channel 2 activity output
   // Needs its own enable as well as the master
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         channel_two_active <= 1'b0;
      end else begin
         channel_two_active <= next_channel_two_active;
      end
   end

   // Channel 3 activity output
   // Its enable counts only behind the master
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         channel_three_active <= 1'b0;
      end else begin
         channel_three_active <= next_channel_three_active;
      end
   end

   // Channel 4 activity output
   // Its enable counts only behind the master
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         channel_four_active <= 1'b0;
      end else begin
         channel_four_active <= next_channel_four_active;
      end
   end

   // Gate A20 activity output
   // Needs its own enable as well as the master
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fast_gate_a20_active <= 1'b0;
      end else begin
         fast_gate_a20_active <= next_fast_gate_a20_active;
      end
   end

   // Channel 2 select output, active high
   // Already gated by the channel 2 enable and the float request
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         channel_two_chip_select <= 1'b0;
      end else begin
         channel_two_chip_select <= next_channel_two_chip_select;
      end
   end
endmodule

// ===== test/hpsc_top_properties.sv
// Concurrent checks on the ports of the system control block
`timescale 1ns/1ps
module hpsc_checker (
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic [3:0] reg_addr,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       single_chip_mode,
   input wire logic       host_port_shutdown_input,
   input wire logic [1:0] port_level_select,
   input wire logic       host_port_active,
   input wire logic       host_pins_float,
   input wire logic       channel_two_active,
   input wire logic       channel_three_active,
   input wire logic       channel_four_active,
   input wire logic       channel_two_chip_select
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // ****************************************
   // Assertions
   // ****************************************
   sequence no_cfg_write;
      !(reg_write && reg_addr == 4'h0) [*3];
   endsequence
   AST_RD_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside slot");
   AST_RSVD: assert property (reg_read && reg_addr == 4'h0 |=> !reg_rdata[4])
      else $error("reserved bit set");
   AST_CH3: assert property (channel_three_active |-> host_port_active)
      else $error("channel 3 without master");
   AST_CH4: assert property (channel_four_active |-> host_port_active)
      else $error("channel 4 without master");
   AST_CH2: assert property (channel_two_active |-> host_port_active)
      else $error("channel 2 without master");
   AST_FLOAT: assert property (host_pins_float |-> !host_port_active && !channel_two_chip_select)
      else $error("host pins active while floating");
   AST_MODE: assert property (!single_chip_mode [*4] |-> !host_port_active)
      else $error("active outside mode");
   AST_SDOFF: assert property (!host_port_shutdown_input [*4] |-> !host_pins_float)
      else $error("float no request");
   AST_CS2: assert property (channel_two_chip_select |-> channel_two_active)
      else $error("select without ch2");
   AST_HOLD: assert property (no_cfg_write |-> $stable(port_level_select))
      else $error("level moved unwritten");
endmodule
bind hpsc_top hpsc_checker u_chk (.*);

// ===== test/tb_host_port_system_control.sv
// Self-checking testbench for the system control block
`timescale 1ns/1ps
module tb_host_port_system_control;
   logic        core_clk, reset, reg_write, reg_read, single_chip_mode, host_port_shutdown_input;
   logic        channel_two_select_n, alternate_channel_two_select_n, pullup_current_limit, host_port_active;
   logic        host_pins_float, channel_two_active, channel_three_active, channel_four_active;
   logic        fast_gate_a20_active, channel_two_chip_select;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   logic [1:0]  port_level_select;
   int          n_fail = 0, check_count = 0;
   logic [15:0] rows [6] = '{16'hEFEF, 16'h0000, 16'h4040, 16'h8080, 16'hC0C0, 16'h2020};
   wire  [7:0]  act = {1'b0, host_port_active, host_pins_float, channel_two_active, channel_three_active,
                       channel_four_active, fast_gate_a20_active, channel_two_chip_select};
   hpsc_top DUT (.*);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // ****************************************
   // Bus tasks and compare
   // ****************************************
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 chk("read data", exp, reg_rdata);
   endtask
   task automatic st(input logic [7:0] exp);
      repeat (5) @(posedge core_clk);
      #1 chk("active outputs", exp, act);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ****************************************
   // Stimulus
   // ****************************************
   initial begin
      reset = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      single_chip_mode = 1'b1;
      host_port_shutdown_input = 1'b0;
      channel_two_select_n = 1'b1;
      alternate_channel_two_select_n = 1'b1;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      rd(4'h0, 8'h00);
      st(8'h00);
      foreach (rows[i]) begin
         wr(4'h0, rows[i][15:8]);
         rd(4'h0, rows[i][7:0]);
         repeat (2) @(posedge core_clk);
         #1 chk("port fields", {5'h00, rows[i][7:5]}, {5'h00, port_level_select, pullup_current_limit});
      end
      wr(4'h1, 8'h01);
      wr(4'h0, 8'h07);
      st(8'h5C);
      @(posedge core_clk);
      channel_two_select_n <= 1'b0;
      st(8'h5D);
      wr(4'h1, 8'h03);
      st(8'h5E);
      @(posedge core_clk);
      alternate_channel_two_select_n <= 1'b0;
      st(8'h5F);
      rd(4'h1, 8'h03);
      rd(4'h2, 8'h3F);
      wr(4'h0, 8'h05);
      st(8'h57);
      wr(4'h0, 8'h06);
      st(8'h00);
      rd(4'h2, 8'h20);
      wr(4'h0, 8'h0F);
      @(posedge core_clk);
      host_port_shutdown_input <= 1'b1;
      st(8'h20);
      rd(4'h2, 8'h7F);
      wr(4'h0, 8'h07);
      st(8'h5F);
      @(posedge core_clk);
      single_chip_mode <= 1'b0;
      st(8'h00);
      rd(4'h2, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      rd(4'h0, 8'h07);
      @(posedge core_clk);
      reset <= 1'b1;
      @(posedge core_clk);
      reset <= 1'b0;
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      stop_test();
   end
   initial begin
      repeat (2000) @(posedge core_clk);
      n_fail++;
      stop_test();
   end
endmodule
